// ---- csc_clk_div.sv ----
/*
 * Converter clock prescaler: divides mclk by a coded factor and emits a
 * one-cycle tick plus a near-square clock enable for the analog switcher.
 * Assumes the code only changes while the converter is off.
 */
`timescale 1ns/1ps
module csc_clk_div
   import csc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic [3:0] code,
   // Output
   output logic            conv_clk,
   output logic            conv_tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic       clk;
      logic       tick;
   } csc_div_st_t;

   csc_div_st_t st_ff;
   csc_div_st_t nxt_st;

   // Reserved codes fall back to the slowest factor, keeping the switcher safe
   function automatic logic [4:0] div_factor(input logic [3:0] c);
      case (c)
         4'h0:    div_factor = CSC_DIV_F0;
         4'h1:    div_factor = CSC_DIV_F1;
         4'h2:    div_factor = CSC_DIV_F2;
         4'h3:    div_factor = CSC_DIV_F3;
         4'h4:    div_factor = CSC_DIV_F4;
         4'h5:    div_factor = CSC_DIV_F5;
         4'h6:    div_factor = CSC_DIV_F6;
         default: div_factor = CSC_DIV_F7;
      endcase
   endfunction

   logic [4:0] fac;

   always_comb begin
      fac = div_factor(code);
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!run) begin
         nxt_st.cnt = 5'h00;
         nxt_st.clk = 1'b0;
      end else if (st_ff.cnt >= fac - 5'h01) begin
         nxt_st.cnt  = 5'h00;
         nxt_st.clk  = 1'b0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 5'h01;
         nxt_st.clk = (st_ff.cnt + 5'h01) >= (fac >> 1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign conv_clk  = st_ff.clk;
   assign conv_tick = st_ff.tick;
endmodule

// ---- csc_pkg.sv ----
/*
 * Package for the card supply converter control block: register offsets,
 * field positions, reset values, scaling tables and converter states.
 * Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
 */
package csc_pkg;
   // Printed index of the control register
   localparam logic [7:0]  CSC_IDX_CTRL   = 8'hbf;
   // Register byte addresses; the control word sits at four times its index
   localparam logic [11:0] CSC_OFF_CTRL   = {2'b00, CSC_IDX_CTRL, 2'b00};
   localparam logic [11:0] CSC_OFF_STAT   = 12'h300;
   localparam logic [11:0] CSC_OFF_IRQST  = 12'h304;
   localparam logic [11:0] CSC_OFF_IRQMSK = 12'h308;
   localparam logic [11:0] CSC_OFF_ON     = 12'h30c;

   // Control field positions
   localparam int CSC_BIT_MODE   = 7;
   localparam int CSC_BIT_OVERCURRENT_LIMIT_ADJUST = 6;
   localparam int CSC_STEP_HI    = 5;
   localparam int CSC_STEP_LO    = 4;
   localparam int CSC_DIV_HI     = 3;
   localparam int CSC_DIV_LO     = 0;
   localparam logic [7:0] CSC_CTRL_RST = 8'h00;

   // Status bits
   localparam int CSC_ST_READY = 0;
   localparam int CSC_ST_OVF   = 1;
   localparam int CSC_ST_ON    = 2;
   // Interrupt event bits
   localparam int CSC_EV_READY = 0;
   localparam int CSC_EV_OVF   = 1;
   localparam int CSC_EV_OUT   = 2;
   localparam int CSC_EV_W     = 3;

   // Limits in percent of nominal
   localparam logic [7:0] CSC_PCT_BASE   = 8'd100;
   localparam logic [7:0] CSC_PCT_ADJ    = 8'd20;
   localparam logic [7:0] CSC_PCT_STEP1  = 8'd30;
   localparam logic [7:0] CSC_PCT_STEP2  = 8'd50;
   localparam logic [7:0] CSC_PCT_STEP3  = 8'd80;
   localparam logic [7:0] CSC_MA_START   = 8'd30;
   localparam logic [7:0] CSC_MA_LIMIT   = 8'd100;

   // Divider factors
   localparam logic [4:0] CSC_DIV_F0 = 5'd2;
   localparam logic [4:0] CSC_DIV_F1 = 5'd3;
   localparam logic [4:0] CSC_DIV_F2 = 5'd4;
   localparam logic [4:0] CSC_DIV_F3 = 5'd5;
   localparam logic [4:0] CSC_DIV_F4 = 5'd6;
   localparam logic [4:0] CSC_DIV_F5 = 5'd8;
   localparam logic [4:0] CSC_DIV_F6 = 5'd10;
   localparam logic [4:0] CSC_DIV_F7 = 5'd24;

   // AXI responses
   localparam logic [1:0] CSC_RESP_OK  = 2'b00;
   localparam logic [1:0] CSC_RESP_ERR = 2'b10;

   typedef enum logic [2:0] {
      CSC_OFF,
      CSC_START,
      CSC_READY,
      CSC_TRIPPED,
      CSC_FAULT
   } csc_state_t;
endpackage

// ---- csc_top.sv ----
/*
 * Card supply converter control: control register, status decode,
 * start-up and overcurrent state machine, interrupts, AXI4-Lite slave.
 * Assumes the analog converter reports regulation and current-limit levels
 * synchronous to mclk, and that software keeps its side of the sequence.
 */
// Behaviour
// [RULE1] Software selects pump mode for 5 V
// [RULE2] Light load reaches ready at lowest step
// [RULE3] Software raises step until ready sets
// [RULE4] Step scales overcurrent trip level equally
// [RULE5] Software lowers step after ready
// [RULE6] Software keeps monitoring both flags
// [RULE7] Sensor off during start; flags stay clear
// [RULE8] Both clear after start means fault
// [RULE9] Overcurrent shutdown: ready 0, overcurrent 1
// [RULE10] Ready 1, overcurrent 0 only when good
// [RULE11] Bit 7 selects pump or regulator
// [RULE12] Bit 6 raises overcurrent limit 20%
// [RULE13] Bits 5-4 scale start and limit current
// [RULE14] Bits 3-0 select clock division factor
// [RULE15] Control register resets to zero
// [RULE16] No start without card; removal shuts down
// [RULE17] Software start sequence order
// [RULE18] Overcurrent flag set while limiting
// [RULE19] Never both flags set together
`timescale 1ns/1ps
module csc_top
   import csc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Card and analog converter
   input  wire logic        card_present_input,
   input  wire logic        conv_in_regulation,
   input  wire logic        conv_current_limit,
   output logic             conv_enable,
   output logic             conv_regulator_mode,
   output logic             conv_sensor_enable,
   output logic [7:0]       conv_start_pct,
   output logic [7:0]       conv_limit_pct,
   output logic             conv_clk,
   output logic             conv_tick,
   // Interrupt
   output logic             irq
);
   typedef struct packed {
      logic [7:0]            ctrl;
      logic                  on_req;
      csc_state_t            state;
      logic                  ready;
      logic                  ovf;
      logic [CSC_EV_W-1:0]   ev;
      logic [CSC_EV_W-1:0]   msk;
      logic                  aw_got;
      logic [11:0]           aw_addr;
      logic                  w_got;
      logic [31:0]           w_data;
      logic                  w_lane0;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
   } csc_st_t;

   csc_st_t st_ff;
   csc_st_t nxt_st;

   // Percent scaling for a current step code
   function automatic logic [7:0] step_pct(input logic [1:0] s);
      case (s)
         2'h1:    step_pct = CSC_PCT_BASE + CSC_PCT_STEP1;
         2'h2:    step_pct = CSC_PCT_BASE + CSC_PCT_STEP2;
         2'h3:    step_pct = CSC_PCT_BASE + CSC_PCT_STEP3;
         default: step_pct = CSC_PCT_BASE;
      endcase
   endfunction

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == CSC_OFF_CTRL) || (a == CSC_OFF_STAT) || (a == CSC_OFF_IRQST)
                   || (a == CSC_OFF_IRQMSK) || (a == CSC_OFF_ON);
   endfunction

   logic [1:0]          step;
   logic                do_wr;
   logic [CSC_EV_W-1:0] ev_set;
   logic [31:0]         rd_word;
   logic [7:0]          limit_base;

   always_comb begin
      nxt_st     = st_ff;
      ev_set     = '0;
      step       = st_ff.ctrl[CSC_STEP_HI:CSC_STEP_LO];
      limit_base = st_ff.ctrl[CSC_BIT_OVERCURRENT_LIMIT_ADJUST] ? CSC_PCT_BASE + CSC_PCT_ADJ : CSC_PCT_BASE;
      rd_word    = 32'h0000_0000;

      // Converter state machine
      case (st_ff.state)
         CSC_OFF: begin
            // [RULE16] Needs card present
            if (st_ff.on_req && card_present_input) begin
               nxt_st.state = CSC_START;
            end
         end
         CSC_START: begin
            // [RULE16] Card removal shuts down
            if (!card_present_input || !st_ff.on_req) begin
               nxt_st.state = CSC_OFF;
            // [RULE7] Overload during start blocks start
            end else if (conv_in_regulation && !conv_current_limit) begin
               // [RULE2] Reaches ready at any step
               nxt_st.state = CSC_READY;
            end
         end
         CSC_READY: begin
            if (!card_present_input || !st_ff.on_req) begin
               nxt_st.state = CSC_OFF;
            // [RULE18] Limiting trips the converter
            end else if (conv_current_limit) begin
               nxt_st.state = CSC_TRIPPED;
            end else if (!conv_in_regulation) begin
               nxt_st.state = CSC_FAULT;
            end
         end
         CSC_TRIPPED, CSC_FAULT: begin
            // Held off until software drops the on bit, so faults stay visible
            if (!st_ff.on_req) begin
               nxt_st.state = CSC_OFF;
            end
         end
         default: nxt_st.state = CSC_OFF;
      endcase

      // [RULE10] Ready only when in regulation
      nxt_st.ready = (nxt_st.state == CSC_READY);
      // [RULE9] Overcurrent shutdown status
      nxt_st.ovf   = (nxt_st.state == CSC_TRIPPED);
      // [RULE19] Flags exclusive by state decode
      if (nxt_st.ready) begin
         nxt_st.ovf = 1'b0;
      end

      ev_set[CSC_EV_READY] = nxt_st.ready & ~st_ff.ready;
      ev_set[CSC_EV_OVF]   = nxt_st.ovf & ~st_ff.ovf;
      ev_set[CSC_EV_OUT]   = (nxt_st.state == CSC_FAULT) && (st_ff.state != CSC_FAULT);

      // Read mux
      case (s_axi_araddr)
         CSC_OFF_CTRL:   rd_word = {24'h000000, st_ff.ctrl};
         CSC_OFF_STAT:   rd_word = {29'h0, st_ff.state != CSC_OFF, st_ff.ovf, st_ff.ready};
         CSC_OFF_IRQST:  rd_word = {29'h0, st_ff.ev};
         CSC_OFF_IRQMSK: rd_word = {29'h0, st_ff.msk};
         CSC_OFF_ON:     rd_word = {31'h0, st_ff.on_req};
         default:        rd_word = 32'h0000_0000;
      endcase

      // Write channel capture, either order
      if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.w_got   = 1'b1;
         nxt_st.w_data  = s_axi_wdata;
         nxt_st.w_lane0 = s_axi_wstrb[0];
      end
      do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
      if (do_wr) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = known_addr(st_ff.aw_addr) ? CSC_RESP_OK : CSC_RESP_ERR;
         if (st_ff.w_lane0) begin
            case (st_ff.aw_addr)
               // [RULE11] [RULE12] [RULE13] [RULE14] Control fields written
               CSC_OFF_CTRL:   nxt_st.ctrl = st_ff.w_data[7:0];
               CSC_OFF_IRQST:  nxt_st.ev   = st_ff.ev & ~st_ff.w_data[CSC_EV_W-1:0];
               CSC_OFF_IRQMSK: nxt_st.msk  = st_ff.w_data[CSC_EV_W-1:0];
               CSC_OFF_ON:     nxt_st.on_req = st_ff.w_data[0];
               default:        nxt_st.ctrl = st_ff.ctrl;
            endcase
         end
      end else if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // Event set wins over a same-cycle clear
      nxt_st.ev = nxt_st.ev | ev_set;

      // Read channel
      if (s_axi_arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd_word;
         nxt_st.rresp  = known_addr(s_axi_araddr) ? CSC_RESP_OK : CSC_RESP_ERR;
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff       <= '0;
         // [RULE15] Control clears on reset
         st_ff.ctrl  <= CSC_CTRL_RST;
         st_ff.state <= CSC_OFF;
      end else begin
         st_ff <= nxt_st;
      end
   end

   csc_clk_div i_csc_clk_div (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .run       (conv_enable),
      .code      (st_ff.ctrl[CSC_DIV_HI:CSC_DIV_LO]),
      .conv_clk  (conv_clk),
      .conv_tick (conv_tick)
   );

   assign conv_enable         = (st_ff.state == CSC_START) || (st_ff.state == CSC_READY);
   assign conv_regulator_mode = st_ff.ctrl[CSC_BIT_MODE];
   // [RULE7] Sensor disabled during start-up
   assign conv_sensor_enable  = (st_ff.state == CSC_READY);
   // [RULE13] Start current scaled by step
   assign conv_start_pct      = step_pct(step);
   // [RULE4] Trip level scales with step; coarse percent, peaks at 200 with bit 6 set
   assign conv_limit_pct      = ((limit_base == CSC_PCT_BASE) || (step_pct(step) < 8'd200))
                                ? step_pct(step) + limit_base - CSC_PCT_BASE : 8'hff;

   assign s_axi_awready = s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready  = s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = s_axi_arvalid && !st_ff.rvalid;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign irq           = |(st_ff.ev & st_ff.msk);
endmodule

// ---- csc_top_checker.sv ----
/*
 * Checker for the card supply converter control block, bound to csc_top.
 * Assumes it sees only the top ports and a single mclk domain.
 */
`timescale 1ns/1ps
module csc_checker
   import csc_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // Register bus
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Converter
   input wire logic        card_present_input,
   input wire logic        conv_in_regulation,
   input wire logic        conv_current_limit,
   input wire logic        conv_enable,
   input wire logic        conv_sensor_enable,
   input wire logic [7:0]  conv_start_pct,
   input wire logic [7:0]  conv_limit_pct,
   input wire logic        conv_clk,
   input wire logic        conv_tick
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_limiting_ready;
      conv_sensor_enable && conv_current_limit;
   endsequence
   a_no_card_off: assert property (!card_present_input |=> !conv_enable) else $error("converter on without card");
   a_sensor_in_ready: assert property (conv_sensor_enable |-> conv_enable) else $error("sensor on while off");
   a_start_sensor_off: assert property ($rose(conv_enable) |-> !conv_sensor_enable) else $error("sensor on in start");
   a_ready_cause: assert property ($rose(conv_sensor_enable) |-> $past(conv_in_regulation) && !$past(conv_current_limit))
      else $error("ready without regulation");
   a_trip_leaves_ready: assert property (s_limiting_ready |=> !conv_sensor_enable) else $error("no trip on limit");
   a_step_pct_set: assert property (conv_start_pct inside {8'd100, 8'd130, 8'd150, 8'd180})
      else $error("bad start percent");
   a_limit_tracks_step: assert property (conv_limit_pct == conv_start_pct || conv_limit_pct == conv_start_pct + 8'd20)
      else $error("limit not tied to step");
   a_tick_one_cycle: assert property (conv_tick |=> !conv_tick) else $error("tick longer than a cycle");
   a_off_clock_quiet: assert property (!conv_enable [*3] |-> !conv_tick && !conv_clk) else $error("clock runs while off");
   a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read answer late");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind csc_top csc_checker i_csc_checker (.mclk(mclk), .rst_n(rst_n), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .card_present_input(card_present_input), .conv_in_regulation(conv_in_regulation),
   .conv_current_limit(conv_current_limit), .conv_enable(conv_enable), .conv_sensor_enable(conv_sensor_enable),
   .conv_start_pct(conv_start_pct), .conv_limit_pct(conv_limit_pct), .conv_clk(conv_clk), .conv_tick(conv_tick));

// ---- csc_top_tb.sv ----
/*
 * Self-checking bench for csc_top: AXI4-Lite master tasks and one task per scenario.
 * Assumes the analog side is played by the bench through the level inputs.
 */
`timescale 1ns/1ps
module csc_top_tb;
   import csc_pkg::*;
   logic        mclk, rst_n, awv, wv, bry, arv, rry, card, inreg, ilim;
   logic [11:0] awa, ara;
   logic [7:0]  spct, lpct;
   logic [31:0] wd, rdat, d;
   logic [3:0]  ws;
   logic [1:0]  br, rr, r;
   logic        awr, wr_rdy, bv, arr, rv, en, mode, sens, cclk, tick, irq;
   int          n_errors, check_count;
   csc_top i_csc_top (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .card_present_input(card),
      .conv_in_regulation(inreg), .conv_current_limit(ilim), .conv_enable(en), .conv_regulator_mode(mode),
      .conv_sensor_enable(sens), .conv_start_pct(spct), .conv_limit_pct(lpct), .conv_clk(cclk),
      .conv_tick(tick), .irq(irq));
   always #10 mclk = ~mclk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Bounded wait on a handshake; a hang ends the run as a failure
   task automatic hang(input int n);
      if (n >= 50) begin
         n_errors++;
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      int n;
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      for (n = 0; n < 50 && (aw || w); n++) begin
         @(posedge mclk);
         if (aw && awr === 1'b1) begin
            aw = 1'b0;
            awv <= 1'b0;
         end
         if (w && wr_rdy === 1'b1) begin
            w = 1'b0;
            wv <= 1'b0;
         end
      end
      hang(n);
      bry <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (bv === 1'b1) break;
      end
      hang(n);
      r = br;
      bry <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      ara <= a;
      arv <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arr === 1'b1) break;
      end
      hang(n);
      arv <= 1'b0;
      rry <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (rv === 1'b1) break;
      end
      hang(n);
      d = rdat;
      r = rr;
      rry <= 1'b0;
   endtask
   task automatic t_reset;
      rd(CSC_OFF_CTRL);
      chk("ctrl reset", d, 32'h0);
      chk("mode reset", mode, 1'b0);
      rd(12'h010);
      chk("unmapped resp", r, CSC_RESP_ERR);
      chk("unmapped data", d, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_fields;
      logic [7:0] pct [4];
      logic [7:0] v;
      pct = '{8'd100, 8'd130, 8'd150, 8'd180};
      for (int i = 0; i < 8; i++) begin
         v = {i[0], i[2:0], 4'h0};
         wr(CSC_OFF_CTRL, {24'h0, v});
         rd(CSC_OFF_CTRL);
         chk("ctrl readback", d, {24'h0, v});
         chk("regulator mode", mode, i[0]);
         chk("start pct", spct, pct[i[1:0]]);
         chk("limit pct", lpct, pct[i[1:0]] + (i[2] ? 8'd20 : 8'd0));
      end
      $display("test fields done");
   endtask
   task automatic t_divider;
      int f [9];
      int n;
      f = '{2, 3, 4, 5, 6, 8, 10, 24, 24};
      for (int c = 0; c < 9; c++) begin
         wr(CSC_OFF_CTRL, c);
         wr(CSC_OFF_ON, 32'h1);
         for (n = 0; n < 100 && tick !== 1'b1; n++) @(posedge mclk);
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (tick !== 1'b1 && n < 100);
         chk("divider period", n, f[c]);
         wr(CSC_OFF_ON, 32'h0);
      end
      $display("test divider done");
   endtask
   task automatic t_start;
      wr(CSC_OFF_CTRL, 32'h0);
      ilim <= 1'b1;
      inreg <= 1'b1;
      wr(CSC_OFF_ON, 32'h1);
      step(5);
      rd(CSC_OFF_STAT);
      chk("overload start flags", d[1:0], 2'b00);
      chk("sensor in start", sens, 1'b0);
      wr(CSC_OFF_CTRL, 32'h10);
      chk("raised start pct", spct, 8'd130);
      ilim <= 1'b0;
      step(3);
      rd(CSC_OFF_STAT);
      chk("ready flags", d[1:0], 2'b01);
      chk("active flag", d[2], 1'b1);
      wr(CSC_OFF_CTRL, 32'h0);
      chk("lowered trip pct", lpct, 8'd100);
      wr(CSC_OFF_IRQMSK, 32'h1);
      chk("ready irq", irq, 1'b1);
      wr(CSC_OFF_IRQST, 32'h1);
      chk("irq cleared", irq, 1'b0);
      wr(CSC_OFF_CTRL, 32'h30);
      chk("raised trip pct", lpct, 8'd180);
      wr(CSC_OFF_CTRL, 32'h0);
      ilim <= 1'b1;
      step(3);
      rd(CSC_OFF_STAT);
      chk("tripped flags", d[1:0], 2'b10);
      chk("tripped off", en, 1'b0);
      wr(CSC_OFF_IRQMSK, 32'h2);
      chk("trip irq", irq, 1'b1);
      ilim <= 1'b0;
      wr(CSC_OFF_ON, 32'h0);
      wr(CSC_OFF_IRQST, 32'h7);
      wr(CSC_OFF_IRQMSK, 32'h0);
      wr(CSC_OFF_ON, 32'h1);
      step(4);
      inreg <= 1'b0;
      step(3);
      rd(CSC_OFF_STAT);
      chk("fault flags", d[1:0], 2'b00);
      chk("masked irq", irq, 1'b0);
      rd(CSC_OFF_IRQST);
      chk("out of spec event", d[2], 1'b1);
      wr(CSC_OFF_ON, 32'h0);
      $display("test start done");
   endtask
   task automatic t_card;
      card <= 1'b0;
      inreg <= 1'b1;
      wr(CSC_OFF_ON, 32'h1);
      step(3);
      chk("no card no start", en, 1'b0);
      card <= 1'b1;
      step(4);
      chk("card starts", en, 1'b1);
      card <= 1'b0;
      step(3);
      chk("removal shuts down", en, 1'b0);
      wr(CSC_OFF_ON, 32'h0);
      card <= 1'b1;
      $display("test card done");
   endtask
   task automatic t_rerst;
      wr(CSC_OFF_CTRL, 32'hff);
      wr(CSC_OFF_ON, 32'h1);
      step(3);
      rst_n <= 1'b0;
      step(2);
      rst_n <= 1'b1;
      step(1);
      chk("reset stops converter", en, 1'b0);
      rd(CSC_OFF_CTRL);
      chk("ctrl after reset", d, 32'h0);
      rd(CSC_OFF_ON);
      chk("on after reset", d, 32'h0);
      $display("test rerst done");
   endtask
   initial begin
      {mclk, rst_n, awv, wv, bry, arv, rry, inreg, ilim} = '0;
      {awa, ara, wd} = '0;
      ws = 4'hf;
      card = 1'b1;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_fields();
      t_divider();
      t_start();
      t_card();
      t_rerst();
      conclude();
   end
endmodule
